// >>> verilog/rtce_pkg.sv
// constants and carrier types for the rule timer and condition engine
package rtce_pkg;
   // ***********************************************
   // rule table geometry
   // ***********************************************
   localparam int RTCE_RULES = 70; // table entries, index 0..69
   localparam int RTCE_IDX_W = 7; // bits of a table index
   localparam logic [6:0] RTCE_LAST_IDX = 7'h45; // highest index (69)
   localparam logic [7:0] RTCE_RULES_B = 8'h46; // entry count as a byte
   localparam logic [7:0] RTCE_VOID = 8'hFF; // void type or void link
   // ***********************************************
   // timers
   // ***********************************************
   localparam int RTCE_N_TMR = 12; // timers 0..11
   localparam int RTCE_N_HI = 8; // timers 0..7 are the fine ones
   localparam int RTCE_TMR_W = 16; // interval counter width
   localparam logic [7:0] RTCE_EVT_TMR_BASE = 8'h0A; // elapse type = base + timer
   // ***********************************************
   // condition types and parameter fields
   // ***********************************************
   localparam logic [7:0] RTCE_C_DET = 8'h32; // detect state test
   localparam logic [7:0] RTCE_C_TMR = 8'h33; // timer running test
   localparam logic [7:0] RTCE_C_V1GT = 8'h34; // variable one above
   localparam logic [7:0] RTCE_C_V1LT = 8'h35; // variable one below
   localparam logic [7:0] RTCE_C_V2GT = 8'h36; // variable two above
   localparam logic [7:0] RTCE_C_V2LT = 8'h37; // variable two below
   localparam logic [7:0] RTCE_DET_NONE = 8'h00; // no detect active
   localparam logic [7:0] RTCE_DET_POS = 8'h01; // positive detect active
   localparam logic [7:0] RTCE_DET_NEG = 8'h02; // negative detect active
   localparam int RTCE_TP_RUN = 7; // timer test: 1 running, 0 stopped
   localparam int RTCE_TP_RSV_HI = 6; // reserved field top
   localparam int RTCE_TP_RSV_LO = 4; // reserved field bottom
   localparam int RTCE_TP_NUM_HI = 3; // timer number field top
   localparam logic [3:0] RTCE_TMR_MAX = 4'hB; // highest valid timer number
   // ***********************************************
   // carriers
   // ***********************************************
   typedef struct packed {
      logic [7:0] b0; // rule type
      logic [7:0] b1; // type-specific parameter / condition link
      logic [7:0] b2; // next link / action link
   } rtce_rule_s;
   typedef struct packed {
      logic wr; // write strobe
      logic [6:0] idx; // entry written
      rtce_rule_s rule; // entry contents
   } rtce_tbl_wr_s;
   typedef struct packed {
      logic start; // start (or restart) the selected timer
      logic cancel; // cancel the selected timer
      logic [3:0] sel; // timer number
      logic [15:0] len; // interval in ticks of that timer
   } rtce_tmr_cmd_s;
   typedef struct packed {
      logic valid; // one-cycle dispatch strobe
      logic [6:0] evt_idx; // matching event rule index
      logic [7:0] act_idx; // first action link of that rule
   } rtce_act_s;
endpackage

// >>> verilog/rtce_engine.sv
// rule timers, elapse events, event scan and condition chain evaluation
//
// Contract
// - eight fine timers 0..7, elapse type 10+n
// - four coarse timers 8..11, types 18..21
// - started timer counts down, one elapse event
// - event rule matches only its own type
// - elapse stops timer, no automatic restart
// - any failing condition suppresses all actions
// - condition: type, parameter, next link
// - chain ends at 255 or past table
// - type 50 tests none/positive/negative detect
// - type 51: bit7 running test, bits3..0 timer
// - running only inside the countdown interval
// - types 52/53 compare variable one
// - types 54/55 compare variable two
// - table of 70 three-byte entries
// - scan up from 0, stop at void
// - condition link 255 or past table: unconditional
`timescale 1ns/10ps
module rtce_engine #(
   parameter int LORES_DIV = 1000 // clocks per coarse timer tick
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire rtce_pkg::rtce_tbl_wr_s i_tbl_wr, // rule table write port
   input wire rtce_pkg::rtce_tmr_cmd_s i_tmr_cmd, // timer start/cancel
   input wire logic i_evt_valid, // outside event offered
   input wire logic [7:0] i_evt_type, // its rule type
   input wire logic i_det_pos, // positive detect active
   input wire logic i_det_neg, // negative detect active
   input wire logic [1:0] i_var_wr, // write variable one / two
   input wire logic [7:0] i_var_data, // value written
   output rtce_pkg::rtce_act_s o_act, // action dispatch
   output logic o_evt_ready, // outside event can be taken
   output logic o_busy, // scan in progress
   output logic [11:0] o_tmr_running // per timer running state
);
   import rtce_pkg::*;

   // ***********************************************
   // storage
   // ***********************************************
   typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_COND} rtce_state_e;
   rtce_rule_s tbl_ff [RTCE_RULES]; // rule table, not reset: software loads it
   rtce_state_e state_ff, nxt_state;
   logic [6:0] scan_ff, nxt_scan; // event rule under test
   logic [6:0] cond_ff, nxt_cond; // condition under test
   logic [7:0] evt_ff; // type of the event being handled
   logic [7:0] var1_ff, var2_ff; // rule variables
   logic [RTCE_N_TMR-1:0] run_ff, pend_ff, el_w, clr_w;
   logic [RTCE_TMR_W-1:0] cnt_ff [RTCE_N_TMR];
   logic [15:0] pre_ff; // coarse prescaler
   logic lo_tick_ff;
   logic [3:0] pick_w; // lowest pending timer
   logic take_ext, take_tmr, cond_ok, dispatch;
   rtce_act_s act_ff;
   logic ready_ff;
   logic busy_ff; // registered non-idle flag, so the output comes from a flop
   rtce_rule_s cur, cnd;

   assign cur = tbl_ff[scan_ff];
   assign cnd = tbl_ff[cond_ff];

   // table write; entries past the last index are dropped
   always_ff @(posedge i_sys_clk) begin
      if (i_tbl_wr.wr && i_tbl_wr.idx <= RTCE_LAST_IDX) begin
         tbl_ff[i_tbl_wr.idx] <= i_tbl_wr.rule;
      end
   end

   // variables are only written by the action side
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         var1_ff <= 8'h00;
         var2_ff <= 8'h00;
      end else begin
         if (i_var_wr[0]) begin
            var1_ff <= i_var_data;
         end
         if (i_var_wr[1]) begin
            var2_ff <= i_var_data;
         end
      end
   end

   // ***********************************************
   // timers
   // ***********************************************
   // coarse tick: one pulse every LORES_DIV clocks
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         pre_ff <= 16'h0000;
         lo_tick_ff <= 1'b0;
      end else begin
         lo_tick_ff <= (pre_ff == 16'(LORES_DIV - 1));
         pre_ff <= (pre_ff == 16'(LORES_DIV - 1)) ? 16'h0000 : pre_ff + 16'h0001;
      end
   end

   for (genvar n = 0; n < RTCE_N_TMR; n++) begin : g_tmr
      logic tick, hit;
      assign tick = (n < RTCE_N_HI) ? 1'b1 : lo_tick_ff;
      assign hit = (i_tmr_cmd.sel == 4'(n));
      // a start or cancel in the elapse cycle wins over the elapse
      assign el_w[n] = run_ff[n] && tick && cnt_ff[n] == 16'h0001
                       && !(hit && (i_tmr_cmd.start || i_tmr_cmd.cancel));
      always_ff @(posedge i_sys_clk or posedge i_reset) begin
         if (i_reset) begin
            run_ff[n] <= 1'b0;
            cnt_ff[n] <= 16'h0000;
         end else if (hit && i_tmr_cmd.start) begin
            run_ff[n] <= 1'b1;
            // a zero interval would never end, so it runs one tick
            cnt_ff[n] <= (i_tmr_cmd.len == 16'h0000) ? 16'h0001 : i_tmr_cmd.len;
         end else if (hit && i_tmr_cmd.cancel) begin
            run_ff[n] <= 1'b0;
         end else if (el_w[n]) begin
            run_ff[n] <= 1'b0;
         end else if (run_ff[n] && tick) begin
            cnt_ff[n] <= cnt_ff[n] - 16'h0001;
         end
      end
   end

   // pending elapse events; a new elapse beats the clear
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= (pend_ff & ~clr_w) | el_w;
      end
   end

   // lowest numbered pending timer is served first
   always_comb begin
      pick_w = 4'h0;
      for (int k = RTCE_N_TMR - 1; k >= 0; k--) begin
         if (pend_ff[k]) begin
            pick_w = 4'(k);
         end
      end
   end

   assign take_ext = (state_ff == ST_IDLE) && ready_ff && i_evt_valid;
   assign take_tmr = (state_ff == ST_IDLE) && !take_ext && (|pend_ff);
   assign clr_w = take_tmr ? (RTCE_N_TMR'(1) << pick_w) : '0;

   // event type latch: outside events take priority over timer elapses
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         evt_ff <= RTCE_VOID;
      end else if (take_ext) begin
         evt_ff <= i_evt_type;
      end else if (take_tmr) begin
         evt_ff <= RTCE_EVT_TMR_BASE + {4'h0, pick_w};
      end
   end

   // ***********************************************
   // condition evaluation
   // ***********************************************
   // the timer number field is trusted only when valid and reserved bits clear
   always_comb begin
      cond_ok = 1'b0;
      case (cnd.b0)
         RTCE_C_DET: begin
            case (cnd.b1)
               RTCE_DET_NONE: cond_ok = !i_det_pos && !i_det_neg;
               RTCE_DET_POS: cond_ok = i_det_pos;
               RTCE_DET_NEG: cond_ok = i_det_neg;
               default: cond_ok = 1'b0;
            endcase
         end
         RTCE_C_TMR: begin
            if (cnd.b1[RTCE_TP_RSV_HI:RTCE_TP_RSV_LO] == 3'h0
                && cnd.b1[RTCE_TP_NUM_HI:0] <= RTCE_TMR_MAX) begin
               cond_ok = run_ff[cnd.b1[RTCE_TP_NUM_HI:0]] == cnd.b1[RTCE_TP_RUN];
            end
         end
         RTCE_C_V1GT: cond_ok = var1_ff > cnd.b1;
         RTCE_C_V1LT: cond_ok = var1_ff < cnd.b1;
         RTCE_C_V2GT: cond_ok = var2_ff > cnd.b1;
         RTCE_C_V2LT: cond_ok = var2_ff < cnd.b1;
         default: cond_ok = 1'b0;
      endcase
   end

   // ***********************************************
   // scan sequencer
   // ***********************************************
   // a looping condition chain is a configuration fault and is not broken
   always_comb begin
      nxt_state = state_ff;
      nxt_scan = scan_ff;
      nxt_cond = cond_ff;
      dispatch = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_scan = 7'h00;
            if (take_ext || take_tmr) begin
               nxt_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (cur.b0 == RTCE_VOID) begin
               nxt_state = ST_IDLE;
            end else if (cur.b0 == evt_ff && cur.b1 < RTCE_RULES_B) begin
               nxt_cond = cur.b1[6:0];
               nxt_state = ST_COND;
            end else begin
               dispatch = (cur.b0 == evt_ff);
               nxt_state = (scan_ff == RTCE_LAST_IDX) ? ST_IDLE : ST_SCAN;
               nxt_scan = scan_ff + 7'h01;
            end
         end
         ST_COND: begin
            if (!cond_ok || cnd.b2 >= RTCE_RULES_B) begin
               dispatch = cond_ok;
               nxt_state = (scan_ff == RTCE_LAST_IDX) ? ST_IDLE : ST_SCAN;
               nxt_scan = scan_ff + 7'h01;
            end else begin
               nxt_cond = cnd.b2[6:0];
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= ST_IDLE;
         scan_ff <= 7'h00;
         cond_ff <= 7'h00;
         ready_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         scan_ff <= nxt_scan;
         cond_ff <= nxt_cond;
         ready_ff <= (nxt_state == ST_IDLE);
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   // dispatch strobe, one cycle per satisfied event rule
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         act_ff <= '0;
      end else begin
         act_ff.valid <= dispatch;
         act_ff.evt_idx <= scan_ff;
         act_ff.act_idx <= cur.b2;
      end
   end

   assign o_act = act_ff;
   assign o_evt_ready = ready_ff;
   assign o_busy = busy_ff;
   assign o_tmr_running = run_ff;

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   sequence s_match_free;
      state_ff == ST_SCAN && cur.b0 == evt_ff && cur.b0 != RTCE_VOID
         && cur.b1 >= RTCE_RULES_B;
   endsequence
   sequence s_cond_fail;
      state_ff == ST_COND && !cond_ok;
   endsequence

   a_elapse_stops: assert property (|el_w |=> (run_ff & $past(el_w)) == '0)
      else $error("timer still running after elapse");
   a_elapse_pends: assert property (|el_w |=> (pend_ff & $past(el_w)) == $past(el_w))
      else $error("elapse event lost");
   a_elapse_type: assert property (take_tmr |=> evt_ff == 8'h0A + {4'h0, $past(pick_w)})
      else $error("elapse type not ten plus timer");
   a_void_stop: assert property (state_ff == ST_SCAN && cur.b0 == RTCE_VOID
      |=> state_ff == ST_IDLE && !act_ff.valid)
      else $error("scan went past void rule");
   a_free_dispatch: assert property (s_match_free |=> act_ff.valid
      && act_ff.evt_idx == $past(scan_ff))
      else $error("unconditional rule not dispatched");
   a_fail_suppress: assert property (s_cond_fail |=> !act_ff.valid)
      else $error("action dispatched despite failed condition");
   a_no_mismatch: assert property (act_ff.valid |-> tbl_ff[act_ff.evt_idx].b0 == evt_ff)
      else $error("dispatch for non matching rule");
   a_equal_false: assert property (state_ff == ST_COND && (cnd.b0 == RTCE_C_V1GT
      || cnd.b0 == RTCE_C_V1LT) && var1_ff == cnd.b1 |-> !cond_ok)
      else $error("equal variable passed strict compare");
   a_reserved_fail: assert property (state_ff == ST_COND && cnd.b0 == RTCE_C_TMR
      && cnd.b1[6:4] != 3'h0 |-> !cond_ok)
      else $error("reserved timer parameter accepted");
   a_fine_timer: assert property (i_tmr_cmd.start && i_tmr_cmd.sel == 4'h0
      && i_tmr_cmd.len == 16'h0003 |=> run_ff[0] ##2 el_w[0] ##1 !run_ff[0])
      else $error("fine timer interval wrong");
endmodule

// >>> verification/tb_rule_timer_condition_engine.sv
// self-checking bench for the rule timer and condition engine
`timescale 1ns/10ps
module tb_rule_timer_condition_engine;
   import rtce_pkg::*;
   // ***********************************************
   // stimulus and observed signals
   // ***********************************************
   logic i_sys_clk = 1'b0; // 125 MHz
   logic i_reset = 1'b1; // held high at start
   rtce_tbl_wr_s i_tbl_wr = '0; // table write port
   rtce_tmr_cmd_s i_tmr_cmd = '0; // timer commands
   logic i_evt_valid = 1'b0; // outside event offered
   logic [7:0] i_evt_type = 8'h00; // its type
   logic i_det_pos = 1'b0; // detect levels
   logic i_det_neg = 1'b0;
   logic [1:0] i_var_wr = 2'h0; // variable writes
   logic [7:0] i_var_data = 8'h00;
   rtce_act_s o_act; // dispatch strobe
   logic o_evt_ready; // engine idle
   logic o_busy; // scan running
   logic [11:0] o_tmr_running; // running bits
   int fail_count = 0; // mismatches
   int n_tests = 0; // comparisons
   logic [15:0] q[$]; // dispatches seen, {evt_idx, act_idx}
   int cnt; // running cycles measured
   // condition cases: {type, parameter, next link, expected}
   logic [31:0] cases [0:21] = '{32'h3200FF00, 32'h3201FF01, 32'h3202FF00, 32'h3203FF00,
      32'h343FFF01, 32'h3440FF00, 32'h3541FF01, 32'h3540FF00, 32'h367FFF01, 32'h3680FF00,
      32'h3781FF01, 32'h3780FF00, 32'h3388FF01, 32'h3308FF00, 32'h3300FF01, 32'h3380FF00,
      32'h3398FF00, 32'h33C8FF00, 32'h3C00FF00, 32'h32010B00, 32'h32010C01, 32'h32015001};
   // coarse tick shortened so the long timers finish quickly
   rtce_engine #(.LORES_DIV(4)) i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_tbl_wr(i_tbl_wr), .i_tmr_cmd(i_tmr_cmd), .i_evt_valid(i_evt_valid),
      .i_evt_type(i_evt_type), .i_det_pos(i_det_pos), .i_det_neg(i_det_neg),
      .i_var_wr(i_var_wr), .i_var_data(i_var_data), .o_act(o_act),
      .o_evt_ready(o_evt_ready), .o_busy(o_busy), .o_tmr_running(o_tmr_running));
   // clock: invert every half period
   always #4 i_sys_clk = ~i_sys_clk;
   // ***********************************************
   // access tasks
   // ***********************************************
   // compare one value; every result fits in 16 bits
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // write one table entry, strobe high for a single edge
   task automatic wr(input logic [6:0] idx, input logic [7:0] a, b, c);
      @(posedge i_sys_clk);
      i_tbl_wr <= '{wr: 1'b1, idx: idx, rule: '{a, b, c}};
      @(posedge i_sys_clk);
      i_tbl_wr.wr <= 1'b0;
   endtask
   // timer command pulse
   task automatic tmr(input logic st, cn, input logic [3:0] sel, input logic [15:0] len);
      @(posedge i_sys_clk);
      i_tmr_cmd <= '{st, cn, sel, len};
      @(posedge i_sys_clk);
      i_tmr_cmd.start <= 1'b0;
      i_tmr_cmd.cancel <= 1'b0;
   endtask
   // record dispatches for a window longer than a full table scan with no conditions
   task automatic collect();
      q.delete();
      repeat (90) begin
         @(negedge i_sys_clk);
         if (o_act.valid === 1'b1) q.push_back({1'b0, o_act.evt_idx, o_act.act_idx});
      end
   endtask
   // offer an outside event, hold it until taken, then gather what it dispatches
   task automatic offer(input logic [7:0] t);
      int k;
      k = 0;
      @(posedge i_sys_clk);
      i_evt_type <= t;
      i_evt_valid <= 1'b1;
      @(negedge i_sys_clk);
      while (o_evt_ready !== 1'b1 && k < 200) begin
         @(negedge i_sys_clk);
         k++;
      end
      @(posedge i_sys_clk);
      i_evt_valid <= 1'b0;
      @(negedge i_sys_clk);
      chk(16'(o_busy), 16'h0001);
      collect();
   endtask
   // closing report, the only place the run ends
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog: the tests need well under 100 us
   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
   // ***********************************************
   // test sequence
   // ***********************************************
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk(16'(o_tmr_running), 16'h0000);
      chk(16'(o_evt_ready), 16'h0001);
      // matching stops at the first void entry; other types never match
      wr(7'h00, 8'h0C, 8'hFF, 8'h05);
      wr(7'h01, 8'h0D, 8'hFF, 8'h06);
      wr(7'h02, 8'h0C, 8'hFF, 8'h07);
      wr(7'h03, 8'hFF, 8'hFF, 8'hFF);
      wr(7'h04, 8'h0C, 8'hFF, 8'h09);
      offer(8'h0C);
      chk(16'(q.size()), 16'h0002);
      chk(q[0], 16'h0005);
      chk(q[1], 16'h0207);
      chk(16'(o_busy), 16'h0000);
      // condition setup: var one 0x40, var two 0x80, positive detect, timer 8 running
      @(posedge i_sys_clk);
      i_var_wr <= 2'h1;
      i_var_data <= 8'h40;
      @(posedge i_sys_clk);
      i_var_wr <= 2'h2;
      i_var_data <= 8'h80;
      @(posedge i_sys_clk);
      i_var_wr <= 2'h0;
      i_det_pos <= 1'b1;
      tmr(1'b1, 1'b0, 4'h8, 16'hFFFF);
      wr(7'h00, 8'h02, 8'h0A, 8'h21);
      wr(7'h01, 8'hFF, 8'hFF, 8'hFF);
      wr(7'h0B, 8'h34, 8'h40, 8'hFF);
      wr(7'h0C, 8'h35, 8'h41, 8'hFF);
      // one chained condition per case, dispatch only when the whole chain holds
      foreach (cases[i]) begin
         wr(7'h0A, cases[i][31:24], cases[i][23:16], cases[i][15:8]);
         offer(8'h02);
         chk(16'(q.size()), {8'h00, cases[i][7:0]});
         if (q.size() > 0) chk(q[0], 16'h0021);
      end
      // condition link past the table end means no conditions at all
      wr(7'h0A, 8'h3C, 8'h00, 8'hFF);
      wr(7'h00, 8'h02, RTCE_RULES_B, 8'h21);
      offer(8'h02);
      chk(16'(q.size()), 16'h0001);
      // a cancelled timer reports stopped
      tmr(1'b0, 1'b1, 4'h8, 16'h0000);
      @(negedge i_sys_clk);
      chk(16'(o_tmr_running), 16'h0000);
      // every timer raises one elapse event of type 10 plus its number
      for (int n = 0; n < 12; n++) begin
         wr(7'(n), 8'(8'h0A + n), 8'hFF, 8'(n));
      end
      wr(7'h0C, 8'hFF, 8'hFF, 8'hFF);
      for (int n = 0; n < 12; n++) begin
         tmr(1'b1, 1'b0, 4'(n), (n < 8) ? 16'(n + 3) : 16'h0003);
         cnt = 0;
         @(negedge i_sys_clk);
         while (o_tmr_running[n] === 1'b1 && cnt < 200) begin
            @(negedge i_sys_clk);
            cnt++;
         end
         if (n < 8) begin
            chk(16'(cnt), 16'(n + 3));
         end else begin
            chk(16'(cnt > 8 && cnt <= 12), 16'h0001);
         end
         collect();
         chk(16'(q.size()), 16'h0001);
         chk(q[0], {1'b0, 7'(n), 8'(n)});
         chk(16'(o_tmr_running), 16'h0000);
      end
      print_verdict();
   end
endmodule
